// ---- ssr_pkg.sv ----
// Package: constants and types for the SPI status readback block
// Behaviour
// - CS fall loads status word, MSB first out
// - After eight bits, echo input delayed eight
// - Latch command only on nonzero multiple-of-eight length
// - CS high floats output, valid frame end reopens fault capture
// - Bad length changes no register or selection
// - Word sampled at CS fall, faults since last
// - Bit 7 returns previous watchdog toggle bit
// - Selector and channel persist until next selection
// - Selector 000 returns channel fault flags
// - Summary fault set by either channel, read-cleared
// - Error pin flags faults, latched cleared switch-on
// - Selector 001 returns sense enables, serial on
// - Selector 010 returns over-current thresholds
// - Selector 011 returns blanking and open-load
// - Selector 100 returns direct-input settings
// - Selector 101 channel 0: delay, fail-safe state
// - Selector 101 channel 1: watchdog period, expiry
// - Selector 110 channel 0: live pin levels
// - Selector 110 channel 1: supply protection disables
// - Selector 111 or none returns null data
package ssr_pkg;

  localparam int              WORD_W   = 8;
  localparam int              CNT_W    = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 3'h1;
  localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;
  // Variant-dependent bit 3 of the null word
  localparam logic            NULL_OD3 = 1'h0;
  // Over-current flags inside a fault vector (latched kind)
  localparam logic [5:0]      FLT_OC_MASK = 6'h18;
  localparam logic [5:0]      FLT_NONE    = 6'h00;

  // Command addresses, also the readback selector codes
  typedef enum logic [2:0] {
    C_SELECT  = 3'b000,
    C_OUTPUT  = 3'b001,
    C_CURRENT = 3'b010,
    C_BLANK   = 3'b011,
    C_DIRECT  = 3'b100,
    C_DELAY   = 3'b101,
    C_MISC    = 3'b110,
    C_TEST    = 3'b111
  } ssr_code_e;

  typedef struct packed {
    logic       ch;
    ssr_code_e  addr;
    logic [3:0] data;
  } ssr_cmd_s;

  typedef struct packed {
    logic overtemp_flag;
    logic high_overcurrent_flag;
    logic low_overcurrent_flag;
    logic open_load_flag;
    logic undervoltage_flag;
    logic overvoltage_flag;
  } ssr_fault_s;

  // input_pin_levels
  typedef struct packed {
    logic in1;
    logic in0;
    logic failsafe_input_pin;
    logic wake;
  } ssr_pins_s;

  typedef struct packed {
    logic ch1_sense_enable;
    logic ch1_serial_on;
    logic ch0_sense_enable;
    logic ch0_serial_on;
  } ssr_outctl_s;

  typedef struct packed {
    logic       high_threshold_select;
    logic [2:0] low_threshold_code;
  } ssr_ocl_s;

  typedef struct packed {
    logic       openload_detect_off;
    logic       blanking_timeout_off;
    logic [1:0] blanking_time_code;
  } ssr_blk_s;

  typedef struct packed {
    logic fast_slew_select;
    logic sense_high_ratio;
    logic direct_input_off;
    logic and_combine;
  } ssr_din_s;

  typedef struct packed {
    ssr_ocl_s ocl;
    ssr_blk_s blk;
    ssr_din_s din;
  } ssr_chcfg_s;

  typedef struct packed {
    logic       spare;
    logic [2:0] turn_on_delay_code;
  } ssr_dly_s;

  typedef struct packed {
    logic [1:0] spare;
    logic [1:0] watchdog_period_code;
  } ssr_wdp_s;

  typedef struct packed {
    logic [1:0] spare;
    logic       undervoltage_protect_off;
    logic       overvoltage_protect_off;
  } ssr_sup_s;

  typedef struct packed {
    logic      spare;
    ssr_code_e readback_selector;
  } ssr_sel_s;

  typedef struct packed {
    logic        wd_toggle;
    ssr_outctl_s outctl;
    ssr_chcfg_s  ch0;
    ssr_chcfg_s  ch1;
    logic [2:0]  turn_on_delay_code;
    logic [1:0]  watchdog_period_code;
    logic        undervoltage_protect_off;
    logic        overvoltage_protect_off;
  } ssr_cfg_s;

  localparam ssr_cfg_s  CFG_RST = '0;
  localparam ssr_code_e SEL_RST = C_TEST;

endpackage : ssr_pkg

// ---- ssr_spi_master_model.sv ----
// Mode-0 SPI master model that frames commands into the readback block
`timescale 1ns/1ps
module ssr_spi_master_model (
  // Serial link driven towards the device
  output logic      SCLK,
  output logic      CS_N,
  output logic      SI,
  // Serial return from the device
  input  wire logic SO,
  input  wire logic SO_OE
);

  // Link idles with the clock low and the device deselected
  initial begin
    SCLK = 1'h0;
    CS_N = 1'h1;
    SI   = 1'h0;
  end

  // One frame of n bits, MSB first; the clock only runs inside the frame.
  // A floating return line reads as z, so an undriven bit never matches.
  task automatic xfer(input logic [15:0] tx, input int n,
                      output logic [15:0] rx);
    rx = 16'h0000;
    #1.7;
    CS_N = 1'h0;
    #20;
    for (int i = n - 1; i >= 0; i--) begin
      SI = tx[i];
      #4;
      SCLK = 1'h1;
      rx[i] = SO_OE ? SO : 1'hz;
      #16;
      SCLK = 1'h0;
      #12;
    end
    CS_N = 1'h1;
    SI = ~SI;  // Released line shows no stale data
    #40;
  endtask : xfer

endmodule : ssr_spi_master_model

// ---- ssr_spi_status_readback.sv ----
// SPI slave: status readback, shift-through and command latch
`timescale 1ns/1ps
module ssr_spi_status_readback
  import ssr_pkg::*;
(
  // System clock, reset, clock enable
  input  wire logic       SYS_CLK,
  input  wire logic       NRST,
  input  wire logic       CLK_EN,
  // Serial link
  input  wire logic       SCLK,
  input  wire logic       CS_N,
  input  wire logic       SI,
  output logic            SO,
  output logic            SO_OE,
  // Device pins
  input  wire logic       IN0_PIN,
  input  wire logic       IN1_PIN,
  input  wire logic       FSI_PIN,
  input  wire logic       WAKE_PIN,
  // Power stage status
  input  wire ssr_fault_s FAULT_CH0,
  input  wire ssr_fault_s FAULT_CH1,
  input  wire logic       WD_EXPIRED,
  input  wire logic       CH0_FS_STATE,
  input  wire logic       CH1_FS_STATE,
  // Configuration and error pin
  output ssr_cfg_s        CFG,
  output logic            ERR_N
);

  // Readback word for the current selection
  function automatic logic [WORD_W-1:0] rb_word(
    input ssr_code_e  sel,
    input logic       ch,
    input ssr_cfg_s   c,
    input logic [5:0] flt,
    input logic       sum,
    input ssr_pins_s  pins,
    input logic       wd,
    input logic       fs0,
    input logic       fs1
  );
    ssr_chcfg_s  k;
    logic [3:0]  n;
    logic [WORD_W-1:0] w;
    k = ch ? c.ch1 : c.ch0;
    n = 4'h0;
    unique case (sel)
      C_OUTPUT:  n = c.outctl;
      C_CURRENT: n = k.ocl;
      C_BLANK:   n = k.blk;
      C_DIRECT:  n = k.din;
      C_DELAY: begin
        if (ch)
          n = {fs1, wd, c.watchdog_period_code};
        else
          n = {fs0, c.turn_on_delay_code};
      end
      C_MISC: begin
        if (ch)
          n = {2'h0, c.undervoltage_protect_off,
               c.overvoltage_protect_off};
        else
          n = pins;
      end
      C_SELECT, C_TEST: n = 4'h0;
    endcase
    if (sel == C_SELECT)
      w = {c.wd_toggle, flt, sum};
    else if (sel == C_TEST)
      w = {c.wd_toggle, 3'h0, NULL_OD3, 3'h0};
    else
      w = {c.wd_toggle, sel, n};
    return w;
  endfunction : rb_word

  // Apply an accepted command to the configuration
  function automatic ssr_cfg_s cfg_apply(
    input ssr_cfg_s c,
    input ssr_cmd_s m
  );
    ssr_cfg_s   r;
    ssr_chcfg_s k;
    ssr_dly_s   dly;
    ssr_wdp_s   wdp;
    ssr_sup_s   sup;
    r   = c;
    k   = m.ch ? c.ch1 : c.ch0;
    dly = ssr_dly_s'(m.data);
    wdp = ssr_wdp_s'(m.data);
    sup = ssr_sup_s'(m.data);
    r.wd_toggle = m.ch;
    unique case (m.addr)
      C_OUTPUT:  r.outctl = ssr_outctl_s'(m.data);
      C_CURRENT: k.ocl = ssr_ocl_s'(m.data);
      C_BLANK:   k.blk = ssr_blk_s'(m.data);
      C_DIRECT:  k.din = ssr_din_s'(m.data);
      C_DELAY: begin
        if (m.ch)
          r.watchdog_period_code = wdp.watchdog_period_code;
        else
          r.turn_on_delay_code = dly.turn_on_delay_code;
      end
      C_MISC: begin
        if (m.ch) begin
          r.undervoltage_protect_off = sup.undervoltage_protect_off;
          r.overvoltage_protect_off  = sup.overvoltage_protect_off;
        end
      end
      C_SELECT, C_TEST: begin
      end
    endcase
    if (m.ch)
      r.ch1 = k;
    else
      r.ch0 = k;
    return r;
  endfunction : cfg_apply

  // Sticky fault capture; new faults win over the clear
  function automatic logic [5:0] next_hold(
    input logic [5:0] hold,
    input logic [5:0] live,
    input logic       clr,
    input logic       son
  );
    logic [5:0] keep;
    keep = clr ? (hold & FLT_OC_MASK) : hold;
    keep = son ? (keep & ~FLT_OC_MASK) : keep;
    return live | keep;
  endfunction : next_hold

  // Reset synchroniser
  logic rst_q1_reg;
  logic rst_n_reg;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST)
      {rst_q1_reg, rst_n_reg} <= 2'h0;
    else if (CLK_EN)
      {rst_q1_reg, rst_n_reg} <= {1'h1, rst_q1_reg};
  end

  // Link-domain state
  logic              act_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic              past8_reg;
  logic              tog_reg;
  logic [WORD_W-1:0] rx_reg;
  logic              started_reg;
  logic              so_reg;
  logic [WORD_W-1:0] snap_reg;
  logic [CNT_W-1:0]  cnt_next;
  logic              past8_next;
  logic              tog_next;
  logic [WORD_W-1:0] rx_next;
  logic              so_next;

  // Bit counting and shift-in; a frame's first edge restarts the count
  assign cnt_next   = act_reg ? cnt_reg + CNT_ONE : CNT_ONE;
  assign past8_next = act_reg & (past8_reg | (cnt_reg == CNT_LAST));
  assign tog_next   = act_reg ? tog_reg : ~tog_reg;
  assign rx_next    = {rx_reg[WORD_W-2:0], SI};
  // Status bits first, then input delayed by a byte
  assign so_next    = past8_reg ? rx_reg[WORD_W-1]
                                : snap_reg[~cnt_reg];

  // In-frame marker, cleared while CS is high
  always_ff @(posedge SCLK or posedge CS_N) begin
    if (CS_N)
      act_reg <= 1'h0;
    else
      act_reg <= 1'h1;
  end

  // Count and data stay put after CS rises so the system side reads them
  always_ff @(posedge SCLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cnt_reg   <= CNT_ZERO;
      past8_reg <= 1'h0;
      tog_reg   <= 1'h0;
      rx_reg    <= '0;
    end else if (!CS_N) begin
      cnt_reg   <= cnt_next;
      past8_reg <= past8_next;
      tog_reg   <= tog_next;
      rx_reg    <= rx_next;
    end
  end

  // Output changes on the falling edge, ahead of master sampling
  always_ff @(negedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      started_reg <= 1'h0;
      so_reg      <= 1'h0;
    end else begin
      started_reg <= 1'h1;
      so_reg      <= so_next;
    end
  end

  // Before the first falling edge the snapshot MSB stands on the pin
  assign SO = started_reg ? so_reg : snap_reg[WORD_W-1];

  // System-side synchronisers
  logic      cs_q1_reg;
  logic      cs_q2_reg;
  logic      cs_q3_reg;
  logic      tog_q1_reg;
  logic      tog_q2_reg;
  ssr_pins_s pin_q1_reg;
  ssr_pins_s pin_q2_reg;
  ssr_pins_s pin_q3_reg;

  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      {cs_q1_reg, cs_q2_reg, cs_q3_reg} <= 3'h7;
      {tog_q1_reg, tog_q2_reg} <= 2'h0;
      pin_q1_reg <= '0;
      pin_q2_reg <= '0;
      pin_q3_reg <= '0;
    end else if (CLK_EN) begin
      {cs_q1_reg, cs_q2_reg, cs_q3_reg} <=
        {CS_N, cs_q1_reg, cs_q2_reg};
      {tog_q1_reg, tog_q2_reg} <= {tog_reg, tog_q1_reg};
      pin_q1_reg <= {IN1_PIN, IN0_PIN, FSI_PIN, WAKE_PIN};
      pin_q2_reg <= pin_q1_reg;
      pin_q3_reg <= pin_q2_reg;
    end
  end

  // System-side registers
  ssr_cfg_s   cfg_reg;
  ssr_code_e  sel_reg;
  logic       selch_reg;
  ssr_code_e  snap_sel_reg;
  logic       seen_reg;
  logic [5:0] hold0_reg;
  logic [5:0] hold1_reg;
  logic       sum_reg;
  logic       so_oe_reg;
  logic       err_n_reg;

  // Frame edges and length check
  ssr_cmd_s   cmd;
  logic       cs_fall;
  logic       cs_rise;
  logic       len_ok;
  logic       end_valid;
  logic       wr_sel;
  logic       wr_out;

  assign cmd       = ssr_cmd_s'(rx_reg);
  assign cs_fall   = cs_q3_reg & ~cs_q2_reg;
  assign cs_rise   = ~cs_q3_reg & cs_q2_reg;
  // Count and data are quiet here: no SCLK edges since CS rose
  assign len_ok    = past8_reg & (cnt_reg == CNT_ZERO)
                   & (tog_q2_reg != seen_reg);
  assign end_valid = cs_rise & len_ok;
  assign wr_sel    = end_valid & (cmd.addr == C_SELECT);
  assign wr_out    = end_valid & (cmd.addr == C_OUTPUT);

  // Faults, masked by the supply protection disables
  logic [5:0] prot_mask;
  logic [5:0] live0;
  logic [5:0] live1;
  logic       any_live;
  logic       son0;
  logic       son1;
  ssr_outctl_s oc_new;

  assign prot_mask = {4'hF, ~cfg_reg.undervoltage_protect_off,
                      ~cfg_reg.overvoltage_protect_off};
  assign live0    = FAULT_CH0 & prot_mask;
  assign live1    = FAULT_CH1 & prot_mask;
  assign any_live = |{live0, live1};
  assign oc_new   = ssr_outctl_s'(cmd.data);
  // Switch-on by serial command or a direct input rising edge
  assign son0 = (wr_out & oc_new.ch0_serial_on
                 & ~cfg_reg.outctl.ch0_serial_on)
              | (pin_q2_reg.in0 & ~pin_q3_reg.in0);
  assign son1 = (wr_out & oc_new.ch1_serial_on
                 & ~cfg_reg.outctl.ch1_serial_on)
              | (pin_q2_reg.in1 & ~pin_q3_reg.in1);

  // Next values
  ssr_cfg_s          cfg_next;
  ssr_code_e         sel_next;
  logic              selch_next;
  logic [5:0]        hold0_next;
  logic [5:0]        hold1_next;
  logic              sum_next;
  logic              err_n_next;
  logic [WORD_W-1:0] word_live;
  ssr_sel_s          sel_cmd;

  assign sel_cmd    = ssr_sel_s'(cmd.data);
  assign cfg_next   = end_valid ? cfg_apply(cfg_reg, cmd)
                                : cfg_reg;
  assign sel_next   = wr_sel ? sel_cmd.readback_selector
                             : sel_reg;
  assign selch_next = wr_sel ? cmd.ch : selch_reg;
  // Faults gather from one valid frame to the next; over-current flags stay until a switch-on
  assign hold0_next = next_hold(hold0_reg, live0, end_valid, son0);
  assign hold1_next = next_hold(hold1_reg, live1, end_valid, son1);
  // Summary: set by either channel, cleared by reading it out
  assign sum_next   = any_live
                    | (sum_reg & ~(end_valid & (snap_sel_reg == C_SELECT)));
  assign err_n_next = ~(any_live
                    | (|(hold0_reg & FLT_OC_MASK))
                    | (|(hold1_reg & FLT_OC_MASK)));
  assign word_live  = rb_word(sel_reg, selch_reg, cfg_reg,
                              selch_reg ? hold1_reg : hold0_reg,
                              sum_reg, pin_q2_reg, WD_EXPIRED,
                              CH0_FS_STATE, CH1_FS_STATE);

  // Configuration, selection and fault state
  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cfg_reg   <= CFG_RST;
      sel_reg   <= SEL_RST;
      selch_reg <= 1'h0;
      hold0_reg <= FLT_NONE;
      hold1_reg <= FLT_NONE;
      sum_reg   <= 1'h0;
      err_n_reg <= 1'h1;
    end else if (CLK_EN) begin
      cfg_reg   <= cfg_next;
      sel_reg   <= sel_next;
      selch_reg <= selch_next;
      hold0_reg <= hold0_next;
      hold1_reg <= hold1_next;
      sum_reg   <= sum_next;
      err_n_reg <= err_n_next;
    end
  end

  // Snapshot at CS fall; a bad frame never moved the selection
  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      snap_reg     <= '0;
      snap_sel_reg <= SEL_RST;
      seen_reg     <= 1'h0;
      so_oe_reg    <= 1'h0;
    end else if (CLK_EN) begin
      if (cs_fall) begin
        snap_reg     <= word_live;
        snap_sel_reg <= sel_reg;
      end
      if (cs_rise)
        seen_reg <= tog_q2_reg;
      so_oe_reg <= ~cs_q2_reg;
    end
  end

  assign SO_OE = so_oe_reg;
  assign CFG   = cfg_reg;
  assign ERR_N = err_n_reg;

  // Checks
  sequence s_good_end;
    cs_rise && len_ok && CLK_EN;
  endsequence

  a_len_reject: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n_reg)
    (cs_rise && !len_ok) |=> $stable(cfg_reg) && $stable(sel_reg))
    else $error("registers changed after a bad-length frame");

  a_out_latch: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n_reg)
    s_good_end ##0 (cmd.addr == C_OUTPUT)
    |=> cfg_reg.outctl == $past(cmd.data))
    else $error("output control not latched on a good frame");

  a_sel_keep: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n_reg)
    !wr_sel |=> $stable(sel_reg) && $stable(selch_reg))
    else $error("selection moved without a selection write");

  a_snap_load: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n_reg)
    (cs_fall && CLK_EN) |=> snap_reg == $past(word_live))
    else $error("status word not captured at CS fall");

  a_oe_idle: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n_reg)
    (cs_q2_reg && CLK_EN) [*2] |-> !so_oe_reg)
    else $error("serial output driven with CS high");

  a_od7_prev: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n_reg)
    s_good_end |=> word_live[WORD_W-1] == $past(cmd.ch))
    else $error("bit 7 does not return the last toggle bit");

  a_null_word: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n_reg)
    (sel_reg == C_TEST)
    |-> word_live[WORD_W-2:0] == {3'h0, NULL_OD3, 3'h0})
    else $error("null selection returned data");

  a_sel_fault: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n_reg)
    (sel_reg == C_SELECT && selch_reg)
    |-> word_live[WORD_W-2:1] == hold1_reg)
    else $error("fault word does not show channel 1 flags");

  a_sum_set: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n_reg)
    (any_live && CLK_EN) |=> sum_reg)
    else $error("summary fault not set");

  a_err_pin: assert property (
    @(posedge SYS_CLK) disable iff (!rst_n_reg)
    (any_live && CLK_EN) |=> !err_n_reg)
    else $error("error pin not asserted on a fault");

  a_echo_delay: assert property (
    @(posedge SCLK) disable iff (CS_N || !rst_n_reg)
    (past8_reg && act_reg) |-> rx_reg[WORD_W-1] == $past(SI, 8))
    else $error("echoed bit is not the input of a byte ago");

endmodule : ssr_spi_status_readback

// ---- ssr_spi_status_readback_bench.sv ----
// Self-checking bench for the SPI status readback block
`timescale 1ns/1ps
module ssr_spi_status_readback_bench
  import ssr_pkg::*;
;
  localparam int LIMIT = 30000;
  logic        sys_clk = 1'h0;
  logic        nrst = 1'h0;
  logic        clk_en = 1'h1;
  logic        sclk, cs_n, si, so, so_oe, err_n;
  logic        in0_pin = 1'h0, in1_pin = 1'h0, fsi_pin = 1'h0;
  logic        wake_pin = 1'h1;
  logic        wd_exp = 1'h0, ch0_fs = 1'h0, ch1_fs = 1'h0;
  ssr_fault_s  fault_ch0 = FLT_NONE, fault_ch1 = FLT_NONE;
  ssr_cfg_s    cfg;
  ssr_cfg_s    sh = CFG_RST;
  ssr_code_e   sel = SEL_RST;
  logic        selch = 1'h0;
  logic        pins_free = 1'h1;
  logic [6:0]  flt7 = 7'h00;
  logic [31:0] seed = 32'h13;
  int          mismatches = 0, comparisons = 0, cycles = 0;

  // Device under test and the master on its link
  ssr_spi_status_readback u_ssr_spi_status_readback (
    .SYS_CLK(sys_clk), .NRST(nrst), .CLK_EN(clk_en), .SCLK(sclk),
    .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe), .IN0_PIN(in0_pin),
    .IN1_PIN(in1_pin), .FSI_PIN(fsi_pin), .WAKE_PIN(wake_pin),
    .FAULT_CH0(fault_ch0), .FAULT_CH1(fault_ch1), .WD_EXPIRED(wd_exp),
    .CH0_FS_STATE(ch0_fs), .CH1_FS_STATE(ch1_fs), .CFG(cfg),
    .ERR_N(err_n));
  ssr_spi_master_model u_ssr_spi_master_model (
    .SCLK(sclk), .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe));

  // System clock and hang guard
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [39:0] exp,
                       input logic [39:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Status word expected for the current selection and channel
  function automatic logic [7:0] exp_word();
    ssr_chcfg_s c;
    logic       w;
    c = selch ? sh.ch1 : sh.ch0;
    w = sh.wd_toggle;
    case (sel)
      C_SELECT:  return {w, flt7};
      C_OUTPUT:  return {w, 3'h1, sh.outctl};
      C_CURRENT: return {w, 3'h2, c.ocl};
      C_BLANK:   return {w, 3'h3, c.blk};
      C_DIRECT:  return {w, 3'h4, c.din};
      C_DELAY:   return selch ?
                   {w, 3'h5, ch1_fs, wd_exp, sh.watchdog_period_code} :
                   {w, 3'h5, ch0_fs, sh.turn_on_delay_code};
      C_MISC:    return selch ? {w, 3'h6, 2'h0,
                   sh.undervoltage_protect_off, sh.overvoltage_protect_off} :
                   {w, 3'h6, in1_pin, in0_pin, fsi_pin, wake_pin};
      default:   return {w, 3'h0, NULL_OD3, 3'h0};
    endcase
  endfunction : exp_word

  // Shadow of what a valid command leaves behind
  function automatic void apply(input logic [7:0] m);
    ssr_chcfg_s c;
    c = m[7] ? sh.ch1 : sh.ch0;
    sh.wd_toggle = m[7];
    case (m[6:4])
      3'h0: begin
        sel = ssr_code_e'(m[2:0]);
        selch = m[7];
      end
      3'h1: sh.outctl = m[3:0];
      3'h2: c.ocl = m[3:0];
      3'h3: c.blk = m[3:0];
      3'h4: c.din = m[3:0];
      3'h5: begin
        if (m[7]) sh.watchdog_period_code = m[1:0];
        else sh.turn_on_delay_code = m[2:0];
      end
      3'h6: begin
        if (m[7]) sh.undervoltage_protect_off = m[1];
        if (m[7]) sh.overvoltage_protect_off = m[0];
      end
      default: ;
    endcase
    if (m[7]) sh.ch1 = c;
    else sh.ch0 = c;
  endfunction : apply

  // One frame with all its checks, then fresh pin levels settle
  task automatic run(input logic [15:0] tx, input int n);
    logic [15:0] rx, mk;
    logic [7:0]  e;
    logic [31:0] r;
    e = exp_word();
    mk = 16'((17'h1 << (n - 8)) - 17'h1);
    u_ssr_spi_master_model.xfer(tx, n, rx);
    if (n >= 8) check("status", 40'(e), 40'(8'(rx >> (n - 8))));
    if (n > 8) check("echo", 40'((tx >> 8) & mk), 40'(rx & mk));
    if (n > 0 && n % 8 == 0) apply(tx[7:0]);
    check("cfg", 40'(sh), 40'(cfg));
    check("so_oe", 40'h0, 40'(so_oe));
    @(negedge sys_clk);
    r = rnd();
    if (pins_free) {in1_pin, in0_pin, fsi_pin, wake_pin} = r[3:0];
    {wd_exp, ch0_fs, ch1_fs} = r[6:4];
    repeat (4) @(negedge sys_clk);
  endtask : run

  // Main sequence
  initial begin
    logic [31:0] r;
    logic [7:0]  m;
    int          lens[5] = '{8, 16, 8, 12, 0};
    repeat (8) @(negedge sys_clk);
    nrst = 1'h1;  // Wake is high here, so the first word is trusted
    repeat (3) @(negedge sys_clk);
    run(16'h0060, 8);
    $display("test reset_null done");
    // Random commands, including long and refused frames
    for (int k = 0; k < 40; k++) begin
      r = rnd();
      m = r[7:0];
      run({r[15:8], m}, lens[k % 5]);
    end
    $display("test random_frames done");
    // Every readback source on both channels
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < 8; s++) begin
        run({8'h00, c[0], 4'h0, s[2:0]}, 8);
        run({8'h00, c[0], 7'h60}, 8);
      end
    end
    $display("test selector_sweep done");
    // Faults; no undervoltage is injected, so no word is discarded
    pins_free = 1'h0;
    run(16'h0001, 8);
    // Frozen system side must not react to a fault
    clk_en = 1'h0;
    fault_ch1 = 6'h20;
    repeat (5) @(negedge sys_clk);
    check("err_n_frozen", 40'h1, 40'(err_n));
    clk_en = 1'h1;
    repeat (5) @(negedge sys_clk);
    check("err_n", 40'h0, 40'(err_n));
    run(16'h0000, 8);
    flt7 = 7'h01;
    run(16'h0060, 8);
    fault_ch1 = FLT_NONE;
    repeat (5) @(negedge sys_clk);
    run(16'h0060, 8);
    flt7 = 7'h00;
    run(16'h0060, 8);
    fault_ch0 = 6'h10;
    repeat (5) @(negedge sys_clk);
    check("err_n", 40'h0, 40'(err_n));
    flt7 = 7'h21;
    run(16'h0010, 8);
    fault_ch0 = FLT_NONE;
    repeat (5) @(negedge sys_clk);
    check("err_n", 40'h0, 40'(err_n));
    run(16'h0060, 8);
    flt7 = 7'h20;
    run(16'h0011, 8);
    check("err_n", 40'h1, 40'(err_n));
    flt7 = 7'h00;
    run(16'h0060, 8);
    $display("test fault_flags done");
    wrap_up();
  end

endmodule : ssr_spi_status_readback_bench
